// File: include/pats_map.svh
// offsets-free constant map: field widths, reset values and timing counts for the pwm timer
`ifndef PATS_MAP_SVH
`define PATS_MAP_SVH
`define PATS_CNT_W 16
`define PATS_CLK_HZ 200000000
`define PATS_TIMER_HZ 160000000
`define PATS_CARRIER_NS 1000000
// half carrier period: triangle goes up then down once per carrier
`define PATS_PERIOD_DEF ((`PATS_TIMER_HZ / 1000) / 2)
`define PATS_DEAD_DEF 16
`define PATS_SKIP_DEF 2
`define PATS_SKIP_W 3
`define PATS_OUT_A_IDLE 1'b1
`define PATS_OUT_B_IDLE 1'b0
`endif

// File: include/pats_pkg.sv
// types for the pwm timer with skipped a/d trigger
package pats_pkg;
	typedef enum logic [1:0] {PATS_IDLE, PATS_UP, PATS_DOWN} pats_state_t;
endpackage

// File: logic/pats_dead_time.sv
// dead time inserter for one complementary output pair
`include "pats_map.svh"
module pats_dead_time
	import pats_pkg::*;
#(
	parameter int CNT_W = `PATS_CNT_W
)
(
	input wire logic ref_clk, // clock
	input wire logic rst, // sync reset
	input wire logic raw_a, // raw first output
	input wire logic raw_b, // raw second output
	input wire logic [CNT_W-1:0] dead_len, // dead time in cycles
	output logic out_a, // delayed first output
	output logic out_b // delayed second output
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic a_q, a_d, b_q, b_d, pa_q, pb_q;

	always_comb
	begin
		cnt_d = cnt_q;
		a_d = a_q;
		b_d = b_q;
		// any edge of either raw output opens a window in which neither output can rise; falls pass at once
		if (raw_a != pa_q || raw_b != pb_q)
		begin
			cnt_d = dead_len;
			a_d = raw_a & a_q;
			b_d = raw_b & b_q;
		end
		else if (cnt_q != '0)
		begin
			cnt_d = cnt_q - 1'b1;
			a_d = raw_a & a_q;
			b_d = raw_b & b_q;
		end
		else
		begin
			a_d = raw_a;
			b_d = raw_b;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			a_q <= `PATS_OUT_A_IDLE;
			b_q <= `PATS_OUT_B_IDLE;
			pa_q <= `PATS_OUT_A_IDLE;
			pb_q <= `PATS_OUT_B_IDLE;
		end
		else
		begin
			cnt_q <= cnt_d;
			a_q <= a_d;
			b_q <= b_d;
			pa_q <= raw_a;
			pb_q <= raw_b;
		end
	end

	assign out_a = a_q;
	assign out_b = b_q;
endmodule

// File: logic/pats_timer.sv
// triangle pwm timer with a/d trigger gated by trough skipping
`include "pats_map.svh"
module pats_timer
	import pats_pkg::*;
#(
	parameter int CNT_W = `PATS_CNT_W,
	parameter int SKIP_W = `PATS_SKIP_W
)
(
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rst, // sync reset, active high
	input wire logic sw_count_start, // software start request level
	input wire logic start_source_enable, // software start source enabled
	input wire logic [CNT_W-1:0] cycle_setting_register, // triangle peak
	input wire logic [CNT_W-1:0] compare_a_register, // compare A
	input wire logic [CNT_W-1:0] compare_b_register, // compare B
	input wire logic [CNT_W-1:0] adc_trigger_compare_register, // a/d trigger compare
	input wire logic [CNT_W-1:0] dead_time_cycles, // dead time length
	input wire logic [SKIP_W-1:0] skip_count_setting, // troughs skipped
	input wire logic skip_link_enable, // link requests to skip function
	output logic [CNT_W-1:0] timer_count_value, // counter value
	output logic pwm_output_first, // first pwm output
	output logic pwm_output_second, // second pwm output
	output logic adc_request_monitor_zero, // request monitor 0
	output logic adc_event_trigger_input, // one-cycle request to event link
	output logic trough_underflow_interrupt, // one-cycle trough interrupt
	output logic [SKIP_W-1:0] skip_count_field, // current skip count
	output logic counting // counter running
);
	// ==========================================================
	// timebase
	// 160 MHz count rate from a 200 MHz clock: fractional enable accumulator
	localparam logic [7:0] RATE_NUM = 8'h04;
	localparam logic [7:0] RATE_DEN = 8'h05;
	logic [7:0] acc_q, acc_d;
	logic tick;
	pats_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic start_s1_q, start_s2_q, en_s1_q, en_s2_q;
	logic run_req;

	assign run_req = start_s2_q & en_s2_q;
	assign tick = (acc_q + RATE_NUM) >= RATE_DEN;

	always_comb
	begin
		acc_d = tick ? 8'(acc_q + RATE_NUM - RATE_DEN) : 8'(acc_q + RATE_NUM);
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			PATS_IDLE:
			begin
				cnt_d = '0;
				if (run_req)
					st_d = PATS_UP;
			end
			PATS_UP:
			begin
				if (!run_req)
					st_d = PATS_IDLE;
				else if (tick)
				begin
					if (cnt_q >= cycle_setting_register)
					begin
						st_d = PATS_DOWN;
						cnt_d = cnt_q - 1'b1;
					end
					else
						cnt_d = cnt_q + 1'b1;
				end
			end
			PATS_DOWN:
			begin
				if (!run_req)
					st_d = PATS_IDLE;
				else if (tick)
				begin
					if (cnt_q == '0)
					begin
						st_d = PATS_UP;
						cnt_d = cnt_q + 1'b1;
					end
					else
						cnt_d = cnt_q - 1'b1;
				end
			end
			default:
				st_d = PATS_IDLE;
		endcase
	end

	// ==========================================================
	// outputs, skip counter and trigger
	logic trough, up_step, match_a, match_b, match_adc;
	logic raw_a_q, raw_a_d, raw_b_q, raw_b_d;
	logic [SKIP_W-1:0] skip_q, skip_d;
	logic req_q, req_d, mon_q, mon_d, irq_q, irq_d;
	logic counting_q, counting_d;
	logic dt_a, dt_b, pa_q, pb_q;

	assign trough = (st_q == PATS_DOWN) && tick && run_req && (cnt_q == '0);
	assign up_step = (st_q != PATS_IDLE) && tick && run_req && (cnt_d != cnt_q);
	assign match_a = up_step && (cnt_d == compare_a_register);
	assign match_b = up_step && (cnt_d == compare_b_register);
	assign match_adc = up_step && (st_d == PATS_UP) && (cnt_d > cnt_q)
		&& (cnt_d == adc_trigger_compare_register);

	always_comb
	begin
		raw_a_d = raw_a_q;
		raw_b_d = raw_b_q;
		if (st_q == PATS_IDLE || !run_req)
		begin
			raw_a_d = `PATS_OUT_A_IDLE;
			raw_b_d = `PATS_OUT_B_IDLE;
		end
		else
		begin
			// peak and trough leave levels alone: cycle end retains
			if (match_a)
				raw_a_d = ~raw_a_q;
			if (match_b)
				raw_b_d = ~raw_b_q;
		end
		skip_d = skip_q;
		if (st_q == PATS_IDLE)
			skip_d = '0;
		else if (trough)
			skip_d = (skip_q >= skip_count_setting) ? '0 : SKIP_W'(skip_q + 1'b1);
		irq_d = trough && (skip_q == '0);
		// requests pass only while skip field is zero when linked
		req_d = match_adc && (!skip_link_enable || skip_q == '0);
		mon_d = req_d;
		// registered so the run flag leaves the block straight from a flop
		counting_d = (st_d != PATS_IDLE);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			start_s1_q <= 1'b0;
			start_s2_q <= 1'b0;
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			acc_q <= 8'h00;
			st_q <= PATS_IDLE;
			cnt_q <= '0;
			raw_a_q <= `PATS_OUT_A_IDLE;
			raw_b_q <= `PATS_OUT_B_IDLE;
			skip_q <= '0;
			req_q <= 1'b0;
			mon_q <= 1'b0;
			irq_q <= 1'b0;
			counting_q <= 1'b0;
			pa_q <= `PATS_OUT_A_IDLE;
			pb_q <= `PATS_OUT_B_IDLE;
		end
		else
		begin
			start_s1_q <= sw_count_start;
			start_s2_q <= start_s1_q;
			en_s1_q <= start_source_enable;
			en_s2_q <= en_s1_q;
			acc_q <= acc_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			raw_a_q <= raw_a_d;
			raw_b_q <= raw_b_d;
			skip_q <= skip_d;
			req_q <= req_d;
			mon_q <= mon_d;
			irq_q <= irq_d;
			counting_q <= counting_d;
			pa_q <= dt_a;
			pb_q <= dt_b;
		end
	end

	pats_dead_time #(.CNT_W(CNT_W)) u_dead
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.raw_a(raw_a_q),
		.raw_b(raw_b_q),
		.dead_len(dead_time_cycles),
		.out_a(dt_a),
		.out_b(dt_b)
	);

	assign timer_count_value = cnt_q;
	assign pwm_output_first = pa_q;
	assign pwm_output_second = pb_q;
	assign adc_event_trigger_input = req_q;
	assign adc_request_monitor_zero = mon_q;
	assign trough_underflow_interrupt = irq_q;
	assign skip_count_field = skip_q;
	assign counting = counting_q;
endmodule

// File: testbench/pats_adc_sink.sv
// event link and converter model: one single scan per accepted start event
module pats_adc_sink
(
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic adc_event_trigger_input, // start event
	output int scans // finished scans
);
	timeunit 1ns;
	timeprecision 100ps;
	int busy;
	// events during a scan are dropped, as a busy converter would
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			busy <= 0;
			scans <= 0;
		end
		else if (busy != 0)
		begin
			busy <= busy - 1;
			if (busy == 1)
				scans <= scans + 1;
		end
		else if (adc_event_trigger_input)
			busy <= 4;
	end
endmodule

// File: testbench/pats_timer_sva.sv
// checker for the pwm timer request gating and output levels
module pats_timer_sva
(
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic [15:0] adc_trigger_compare_register, // trigger
	input wire logic skip_link_enable, // link
	input wire logic [2:0] skip_count_setting, // skip count
	input wire logic [15:0] timer_count_value, // count
	input wire logic pwm_output_first, // out a
	input wire logic pwm_output_second, // out b
	input wire logic adc_request_monitor_zero, // monitor
	input wire logic adc_event_trigger_input, // request
	input wire logic trough_underflow_interrupt, // trough irq
	input wire logic [2:0] skip_count_field, // skip field
	input wire logic counting // running
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// properties
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	a_req_one_cycle: assert property (adc_event_trigger_input |=> !adc_event_trigger_input)
		else $error("request longer than one cycle");
	a_monitor_same: assert property (adc_request_monitor_zero == adc_event_trigger_input)
		else $error("monitor differs from request");
	// request leaves on the same edge that loads the matching count
	a_req_at_match: assert property (adc_event_trigger_input |->
		timer_count_value == adc_trigger_compare_register)
		else $error("request without trigger match");
	a_req_going_up: assert property (adc_event_trigger_input |->
		$past(timer_count_value) < timer_count_value)
		else $error("request while counting down");
	// gate decision uses the skip field of the cycle before the pulse
	a_req_skip_zero: assert property (adc_event_trigger_input && $past(skip_link_enable) |->
		$past(skip_count_field) == 3'h0)
		else $error("request passed with skip field nonzero");
	a_no_req_stopped: assert property (!counting && !$past(counting) |->
		!adc_event_trigger_input)
		else $error("request while stopped");
	// stopping clears the field, which is not a trough step
	a_skip_steps: assert property ($changed(skip_count_field) |-> (!counting && skip_count_field == 3'h0) || skip_count_field ==
		(($past(skip_count_field) == skip_count_setting) ? 3'h0 : $past(skip_count_field) + 3'h1))
		else $error("skip field stepped wrongly");
	a_irq_trough: assert property (trough_underflow_interrupt |->
		skip_count_field inside {3'h0, 3'h1} && timer_count_value < 16'h0003)
		else $error("trough interrupt not skipped");
	// dead time and output lag fit inside eight idle cycles
	a_idle_outputs: assert property (!counting [*8] |-> pwm_output_first && !pwm_output_second)
		else $error("outputs not at idle levels");
	c_req: cover property (adc_event_trigger_input);
	c_irq: cover property (trough_underflow_interrupt);
	c_skip_two: cover property (skip_count_field == 3'h2);
endmodule

bind pats_timer pats_timer_sva pats_timer_sva_i (.ref_clk(ref_clk), .rst(rst),
	.adc_trigger_compare_register(adc_trigger_compare_register),
	.skip_link_enable(skip_link_enable), .skip_count_setting(skip_count_setting),
	.timer_count_value(timer_count_value), .pwm_output_first(pwm_output_first),
	.pwm_output_second(pwm_output_second), .adc_request_monitor_zero(adc_request_monitor_zero),
	.adc_event_trigger_input(adc_event_trigger_input),
	.trough_underflow_interrupt(trough_underflow_interrupt),
	.skip_count_field(skip_count_field), .counting(counting));

// File: testbench/tb_top.sv
// bench for the pwm timer with skipped a/d trigger
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, rst = 1, start = 0, en = 0, link = 1;
	logic [15:0] per = 16'h0014, ca = 16'h0008, cb = 16'h000C, trig = 16'h000A, dead = 16'h0004;
	logic [2:0] skn = 3'h2;
	logic [15:0] cnt;
	logic out_a, out_b, mon, req, irq, run;
	logic [2:0] skip;
	int n_errors, checked, n_req, n_irq, n_mon, scans;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
		$display("unexpected %0t got %0h want %0h", $time, a, b); end end
	pats_timer pats_timer_i (.ref_clk(ref_clk), .rst(rst), .sw_count_start(start),
		.start_source_enable(en), .cycle_setting_register(per), .compare_a_register(ca),
		.compare_b_register(cb), .adc_trigger_compare_register(trig), .dead_time_cycles(dead),
		.skip_count_setting(skn), .skip_link_enable(link), .timer_count_value(cnt),
		.pwm_output_first(out_a), .pwm_output_second(out_b), .adc_request_monitor_zero(mon),
		.adc_event_trigger_input(req), .trough_underflow_interrupt(irq),
		.skip_count_field(skip), .counting(run));
	pats_adc_sink pats_adc_sink_i (.ref_clk(ref_clk), .rst(rst),
		.adc_event_trigger_input(req), .scans(scans));
	initial
	begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (!rst)
		begin
			n_req += req;
			n_irq += irq;
			n_mon += mon;
		end
	task conclude();
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_cnt(input logic [15:0] v);
		int i;
		for (i = 0; i < 200 && cnt !== v; i++)
			@(posedge ref_clk);
		if (i == 200)
		begin
			$display("unexpected %0t timeout", $time);
			n_errors++;
			conclude();
		end
	endtask
	// one carrier is a climb to the peak and the fall back to the trough
	task automatic carriers(input int k);
		repeat (k)
		begin
			wait_cnt(per);
			wait_cnt(16'h0000);
		end
	endtask
	// ==========================================
	// sequence
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		start <= 1;
		repeat (12) @(posedge ref_clk);
		`CHK(run, 1'b0)
		`CHK(cnt, 16'h0000)
		`CHK(out_a, 1'b1)
		`CHK(out_b, 1'b0)
		en <= 1;
		// without dead time the second output would already be high here
		wait_cnt(cb);
		repeat (3) @(posedge ref_clk);
		`CHK(out_b, 1'b0)
		wait_cnt(per);
		`CHK(out_a, 1'b0)
		`CHK(out_b, 1'b1)
		wait_cnt(16'h0000);
		`CHK(out_a, 1'b1)
		`CHK(out_b, 1'b0)
		carriers(5);
		repeat (4) @(posedge ref_clk);
		`CHK(n_req, 2)
		`CHK(n_irq, 2)
		`CHK(scans, 2)
		link <= 0;
		carriers(3);
		repeat (4) @(posedge ref_clk);
		`CHK(n_req, 5)
		`CHK(n_irq, 3)
		`CHK(n_mon, 5)
		`CHK(scans, 5)
		start <= 0;
		repeat (20) @(posedge ref_clk);
		`CHK(run, 1'b0)
		`CHK(out_a, 1'b1)
		`CHK(out_b, 1'b0)
		`CHK(n_req, 5)
		conclude();
	end
endmodule
